// File: hw/crcu_defines.svh
// Register indices, field positions, reset values and counts of the CRC calculation unit.
// What this block does
// - CRC width and polynomial are programmable, up to sixteen bits.
// - Auto bit picks source: 0 input buffer byte, 1 RAM via channel 3.
// - Writing run 1 starts the engine; hardware clears run when finished.
// - Bit order bit: 0 feeds least significant bit first, 1 most significant.
// - Window select maps the shared pair to result (0) or polynomial (1).
// - Completion flag sets at the end and stays until software writes 0.
// - Completion flag and interrupt enable both 1 raise the interrupt request.
// - Result pair: low eight CRC bits at lower address, high at upper.
// - Input buffer is an eight-bit read/write register reset to zero.
// - Channel 3 wait inhibit: 0 permits CPU wait insertion, 1 forbids it.
// - Channel 3 steal inhibit: 0 permits cycle stealing, 1 forbids it.
// - Channel 3 base is high register shifted eight plus low register upper nibble.
// - Count is low nibble and count byte, twelve bits, plus two; one per byte.
`ifndef CRCU_DEFINES_SVH
`define CRCU_DEFINES_SVH

`define CRCU_IDX_INBUF 15'h7fb8
`define CRCU_IDX_CTRL 15'h7fb9
`define CRCU_IDX_PAIR_LO 15'h7fba
`define CRCU_IDX_PAIR_HI 15'h7fbb
`define CRCU_IDX_WIDTH 15'h7fbc
`define CRCU_IDX_X3_ADDR_LO 15'h7fe6
`define CRCU_IDX_X3_ADDR_HI 15'h7fe7
`define CRCU_IDX_X3_COUNT 15'h7fec
`define CRCU_IDX_XTEST 15'h7ffe
`define CRCU_IDX_XCTRL 15'h7fff

`define CRCU_CTL_IE 0
`define CRCU_CTL_END 1
`define CRCU_CTL_SEL 2
`define CRCU_CTL_DIR 3
`define CRCU_CTL_AUTO 4
`define CRCU_CTL_RUN 5

`define CRCU_XC_STEAL_INH 0
`define CRCU_XC_WAIT_INH 1

`define CRCU_RST_BYTE 8'h00
`define CRCU_RST_CRC 16'h0000
`define CRCU_RST_POLY 16'h0000
`define CRCU_RST_WIDTH_M1 4'hf
`define CRCU_RST_XCTRL 6'h00
`define CRCU_RST_X3_HI 7'h00

`define CRCU_BITS_PER_BYTE 4'h8
`define CRCU_COUNT_BIAS 13'h0002
`define CRCU_IRQ_VECTOR 24'h00803c

`endif

// File: hw/crcu_pkg.sv
// Types shared by the CRC calculation unit files.
package crcu_pkg;

	typedef enum logic [1:0] {
		CRCU_IDLE = 2'b00,
		CRCU_FETCH = 2'b01,
		CRCU_SHIFT = 2'b11
	} crcu_state_t;

	typedef struct packed {
		logic [15:0] poly;
		logic [3:0] width_m1;
		logic msb_first;
	} crcu_cfg_t;

	typedef struct packed {
		logic active;
		logic write;
		logic rd_wait;
		logic [14:0] idx;
	} crcu_dphase_t;

	typedef struct packed {
		logic run;
		logic auto_src;
		logic msb_first;
		logic window_select;
		logic done_flag;
		logic irq_enable;
	} crcu_ctrl_t;

endpackage

// File: hw/crcu_engine.sv
// Serial CRC shift engine with byte-wide seed writes.
`timescale 1ns/10ps
`include "crcu_defines.svh"

module crcu_engine (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Configuration.
	input crcu_pkg::crcu_cfg_t cfg,
	// Byte to process.
	input wire logic start,
	input wire logic [7:0] data,
	// Seed writes.
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	// Result and status.
	output logic [15:0] crc,
	output logic busy,
	output logic done
);

	logic [15:0] crc_reg, crc_next;
	logic [7:0] sh_reg, sh_next;
	logic [3:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic in_bit;
	logic fb;
	logic [15:0] mask;

	function automatic logic [15:0] width_mask(input logic [3:0] w_m1);
		logic [15:0] m;
		m = 16'hffff >> (4'hf - w_m1);
		return m;
	endfunction

	always_comb begin
		crc_next = crc_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		mask = width_mask(cfg.width_m1);
		in_bit = cfg.msb_first ? sh_reg[7] : sh_reg[0];
		fb = in_bit ^ crc_reg[cfg.width_m1];
		if (busy_reg) begin
			// One polynomial step per clock keeps the logic to a single XOR layer.
			crc_next = ((crc_reg << 1) ^ (fb ? cfg.poly : 16'h0000)) & mask;
			sh_next = cfg.msb_first ? {sh_reg[6:0], 1'b0} : {1'b0, sh_reg[7:1]};
			cnt_next = cnt_reg - 4'h1;
			if (cnt_reg == 4'h1) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end
		end else if (start) begin
			sh_next = data;
			cnt_next = `CRCU_BITS_PER_BYTE;
			busy_next = 1'b1;
		end
		if (wr_lo) begin
			crc_next[7:0] = wdata & mask[7:0];
		end
		if (wr_hi) begin
			crc_next[15:8] = wdata & mask[15:8];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			crc_reg <= `CRCU_RST_CRC;
			sh_reg <= 8'h00;
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			crc_reg <= crc_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign crc = crc_reg;
	assign busy = busy_reg;
	assign done = done_reg;

endmodule // crcu_engine

// File: hw/crcu_top.sv
// CRC calculation unit: AHB-Lite registers, source sequencer and channel 3 fetch port.
`timescale 1ns/10ps
`include "crcu_defines.svh"

module crcu_top (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Channel 3 RAM fetch port.
	output logic ram_req,
	output logic [15:0] ram_addr,
	input wire logic ram_ack,
	input wire logic [7:0] ram_rdata,
	input wire logic ram_bus_idle,
	output logic cpu_wait,
	// Interrupt.
	output logic irq,
	output logic [23:0] irq_vector
);

	crcu_pkg::crcu_dphase_t dp_reg, dp_next;
	crcu_pkg::crcu_ctrl_t ctl_reg, ctl_next;
	crcu_pkg::crcu_cfg_t cfg;
	crcu_pkg::crcu_state_t state_reg, state_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [7:0] inbuf_reg, inbuf_next;
	logic [15:0] poly_reg, poly_next;
	logic [3:0] width_reg, width_next;
	logic [7:0] x3_lo_reg, x3_lo_next;
	logic [6:0] x3_hi_reg, x3_hi_next;
	logic [7:0] x3_cnt_reg, x3_cnt_next;
	logic [7:0] xtest_reg, xtest_next;
	logic [5:0] xctrl_reg, xctrl_next;
	logic [15:0] addr_reg, addr_next;
	logic [12:0] remain_reg, remain_next;
	logic accept;
	logic wr_now;
	logic [7:0] wbyte;
	logic go;
	logic finish;
	logic eng_start;
	logic [7:0] eng_data;
	logic eng_wr_lo;
	logic eng_wr_hi;
	logic [15:0] crc;
	logic eng_busy;
	logic eng_done;
	logic [7:0] rd_byte;
	logic ctl_wr;
	logic ram_take;
	logic last_byte;

	function automatic logic hit(input logic [14:0] idx, input logic [14:0] target);
		return idx == target;
	endfunction

	// Bus side.
	assign accept = hsel && hready && htrans[1];
	assign wr_now = dp_reg.active && dp_reg.write && hready;
	assign wbyte = hwdata[7:0];

	always_comb begin
		dp_next = dp_reg;
		if (hready) begin
			dp_next.active = accept;
			dp_next.write = hwrite;
			dp_next.rd_wait = accept && !hwrite;
			dp_next.idx = haddr[16:2];
		end else begin
			// The read wait state lasts exactly one cycle.
			dp_next.rd_wait = 1'b0;
		end
	end

	// Read mux; captured in the wait state so hrdata comes from a flip-flop.
	always_comb begin
		rd_byte = 8'h00;
		unique case (dp_reg.idx)
			`CRCU_IDX_INBUF: rd_byte = inbuf_reg;
			`CRCU_IDX_CTRL: rd_byte = {2'b00, ctl_reg.run, ctl_reg.auto_src, ctl_reg.msb_first,
				ctl_reg.window_select, ctl_reg.done_flag, ctl_reg.irq_enable};
			`CRCU_IDX_PAIR_LO: rd_byte = ctl_reg.window_select ? poly_reg[7:0] : crc[7:0];
			`CRCU_IDX_PAIR_HI: rd_byte = ctl_reg.window_select ? poly_reg[15:8] : crc[15:8];
			`CRCU_IDX_WIDTH: rd_byte = {4'h0, width_reg};
			`CRCU_IDX_X3_ADDR_LO: rd_byte = x3_lo_reg;
			`CRCU_IDX_X3_ADDR_HI: rd_byte = {1'b0, x3_hi_reg};
			`CRCU_IDX_X3_COUNT: rd_byte = x3_cnt_reg;
			`CRCU_IDX_XTEST: rd_byte = xtest_reg;
			`CRCU_IDX_XCTRL: rd_byte = {2'b00, xctrl_reg};
			// Unmapped indices read as zero.
			default: rd_byte = 8'h00;
		endcase
		hrdata_next = hrdata_reg;
		if (dp_reg.rd_wait) begin
			hrdata_next = {24'h000000, rd_byte};
		end
	end

	assign hreadyout = !dp_reg.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Plain configuration registers.
	always_comb begin
		inbuf_next = inbuf_reg;
		poly_next = poly_reg;
		width_next = width_reg;
		x3_lo_next = x3_lo_reg;
		x3_hi_next = x3_hi_reg;
		x3_cnt_next = x3_cnt_reg;
		xtest_next = xtest_reg;
		xctrl_next = xctrl_reg;
		if (wr_now) begin
			if (hit(dp_reg.idx, `CRCU_IDX_INBUF)) begin
				inbuf_next = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_PAIR_LO) && ctl_reg.window_select) begin
				poly_next[7:0] = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_PAIR_HI) && ctl_reg.window_select) begin
				poly_next[15:8] = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_WIDTH)) begin
				width_next = wbyte[3:0];
			end
			if (hit(dp_reg.idx, `CRCU_IDX_X3_ADDR_LO)) begin
				x3_lo_next = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_X3_ADDR_HI)) begin
				x3_hi_next = wbyte[6:0];
			end
			if (hit(dp_reg.idx, `CRCU_IDX_X3_COUNT)) begin
				x3_cnt_next = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_XTEST)) begin
				xtest_next = wbyte;
			end
			if (hit(dp_reg.idx, `CRCU_IDX_XCTRL)) begin
				xctrl_next = wbyte[5:0];
			end
		end
	end

	assign eng_wr_lo = wr_now && hit(dp_reg.idx, `CRCU_IDX_PAIR_LO) && !ctl_reg.window_select;
	assign eng_wr_hi = wr_now && hit(dp_reg.idx, `CRCU_IDX_PAIR_HI) && !ctl_reg.window_select;
	assign ram_take = ram_req && ram_ack;
	assign last_byte = remain_reg == 13'h0001;
	assign ctl_wr = wr_now && hit(dp_reg.idx, `CRCU_IDX_CTRL);

	// A run request is honoured only from idle; a second write of 1 mid-run does nothing.
	assign go = ctl_wr && wbyte[`CRCU_CTL_RUN] && !eng_busy
		&& (state_reg == crcu_pkg::CRCU_IDLE);

	// Control register.
	always_comb begin
		ctl_next = ctl_reg;
		if (ctl_wr) begin
			ctl_next.auto_src = wbyte[`CRCU_CTL_AUTO];
			ctl_next.msb_first = wbyte[`CRCU_CTL_DIR];
			ctl_next.window_select = wbyte[`CRCU_CTL_SEL];
			ctl_next.irq_enable = wbyte[`CRCU_CTL_IE];
			if (!wbyte[`CRCU_CTL_END]) begin
				ctl_next.done_flag = 1'b0;
			end
		end
		if (go) begin
			ctl_next.run = 1'b1;
		end
		// Coming last, the completion set wins over a clear written in the same cycle.
		if (finish) begin
			ctl_next.run = 1'b0;
			ctl_next.done_flag = 1'b1;
		end
	end

	// Source sequencer.
	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		remain_next = remain_reg;
		eng_start = 1'b0;
		eng_data = inbuf_reg;
		finish = 1'b0;
		unique case (state_reg)
			crcu_pkg::CRCU_IDLE: begin
				if (go) begin
					if (wbyte[`CRCU_CTL_AUTO]) begin
						// Base and count are latched here, so later writes only shape the next job.
						addr_next = {1'b0, x3_hi_reg, x3_lo_reg[7:4], 4'h0};
						remain_next = {1'b0, x3_lo_reg[3:0], x3_cnt_reg} + `CRCU_COUNT_BIAS;
						state_next = crcu_pkg::CRCU_FETCH;
					end else begin
						eng_start = 1'b1;
						state_next = crcu_pkg::CRCU_SHIFT;
					end
				end
			end
			crcu_pkg::CRCU_FETCH: begin
				eng_data = ram_rdata;
				// Read data are taken only in the answer cycle; an answer without a request is ignored.
				if (ram_take) begin
					eng_start = 1'b1;
					state_next = crcu_pkg::CRCU_SHIFT;
				end
			end
			crcu_pkg::CRCU_SHIFT: begin
				if (eng_done) begin
					if (!ctl_reg.auto_src) begin
						finish = 1'b1;
						state_next = crcu_pkg::CRCU_IDLE;
					end else begin
						// RAM (auto) mode only: one byte per step, address and count move by one.
						addr_next = addr_reg + 16'h0001;
						remain_next = remain_reg - 13'h0001;
						if (last_byte) begin
							finish = 1'b1;
							state_next = crcu_pkg::CRCU_IDLE;
						end else begin
							state_next = crcu_pkg::CRCU_FETCH;
						end
					end
				end
			end
			default: state_next = crcu_pkg::CRCU_IDLE;
		endcase
	end

	// Fetching waits for an idle bus when stealing is forbidden.
	assign ram_req = (state_reg == crcu_pkg::CRCU_FETCH)
		&& (!xctrl_reg[`CRCU_XC_STEAL_INH] || ram_bus_idle);
	assign cpu_wait = ram_req && !xctrl_reg[`CRCU_XC_WAIT_INH];
	assign ram_addr = addr_reg;
	assign irq = ctl_reg.done_flag && ctl_reg.irq_enable;
	assign irq_vector = `CRCU_IRQ_VECTOR;

	// Engine configuration.
	always_comb begin
		cfg.poly = poly_reg;
		cfg.width_m1 = width_reg;
		cfg.msb_first = ctl_reg.msb_first;
	end

	crcu_engine u_engine (
		.hclk(hclk),
		.hresetn(hresetn),
		.cfg(cfg),
		.start(eng_start),
		.data(eng_data),
		.wr_lo(eng_wr_lo),
		.wr_hi(eng_wr_hi),
		.wdata(wbyte),
		.crc(crc),
		.busy(eng_busy),
		.done(eng_done)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_reg <= '0;
			hrdata_reg <= 32'h00000000;
			ctl_reg <= '0;
			state_reg <= crcu_pkg::CRCU_IDLE;
			inbuf_reg <= `CRCU_RST_BYTE;
			poly_reg <= `CRCU_RST_POLY;
			width_reg <= `CRCU_RST_WIDTH_M1;
			x3_lo_reg <= `CRCU_RST_BYTE;
			x3_hi_reg <= `CRCU_RST_X3_HI;
			x3_cnt_reg <= `CRCU_RST_BYTE;
			xtest_reg <= `CRCU_RST_BYTE;
			xctrl_reg <= `CRCU_RST_XCTRL;
			addr_reg <= 16'h0000;
			remain_reg <= 13'h0000;
		end else begin
			dp_reg <= dp_next;
			hrdata_reg <= hrdata_next;
			ctl_reg <= ctl_next;
			state_reg <= state_next;
			inbuf_reg <= inbuf_next;
			poly_reg <= poly_next;
			width_reg <= width_next;
			x3_lo_reg <= x3_lo_next;
			x3_hi_reg <= x3_hi_next;
			x3_cnt_reg <= x3_cnt_next;
			xtest_reg <= xtest_next;
			xctrl_reg <= xctrl_next;
			addr_reg <= addr_next;
			remain_reg <= remain_next;
		end
	end

endmodule // crcu_top

// File: verif/crcu_checker.sv
// Port-level assertions for the CRC calculation unit.
`timescale 1ns/10ps
module crcu_checker (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Register bus.
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	// Fetch port.
	input wire logic ram_req,
	input wire logic [15:0] ram_addr,
	input wire logic ram_ack,
	input wire logic cpu_wait,
	// Interrupt.
	input wire logic irq,
	input wire logic [23:0] irq_vector
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic take;
	assign take = hsel && hready && htrans[1];
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	wait_needs_fetch_a: assert property (cpu_wait |-> ram_req)
		else $error("cpu wait without fetch");
	irq_vector_a: assert property (irq_vector == 24'h00803c)
		else $error("interrupt vector wrong");
	fetch_addr_hold_a: assert property (ram_req && !ram_ack ##1 ram_req |-> $stable(ram_addr))
		else $error("fetch address moved before answer");
	byte_shift_a: assert property (ram_req && ram_ack |=> !ram_req [*8])
		else $error("next fetch before eight shifts");
	irq_clear_a: assert property ($fell(irq) |-> $past(take && hwrite, 2))
		else $error("interrupt dropped without a write");
endmodule // crcu_checker

// File: verif/crcu_ram_model.sv
// Behavioural RAM answering the channel 3 fetch port.
`timescale 1ns/10ps
module crcu_ram_model (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Fetch port.
	input wire logic ram_req,
	input wire logic [15:0] ram_addr,
	input wire logic slow,
	output logic ram_ack,
	output logic [7:0] ram_rdata
);
	logic [1:0] wait_reg;
	// A slow answer lets the request stand three more cycles first.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ram_ack <= 1'b0;
			ram_rdata <= 8'h00;
			wait_reg <= 2'h0;
		end else if (ram_req && !ram_ack && (!slow || wait_reg == 2'h3)) begin
			ram_ack <= 1'b1;
			ram_rdata <= ram_addr[7:0] ^ 8'ha5;
			wait_reg <= 2'h0;
		end else begin
			ram_ack <= 1'b0;
			// Stale data is inverted so nothing can lean on an old byte.
			ram_rdata <= ~ram_rdata;
			wait_reg <= ram_req ? wait_reg + 2'h1 : 2'h0;
		end
	end
endmodule // crcu_ram_model

// File: verif/tb.sv
// Self-checking bench for the CRC calculation unit.
`timescale 1ns/10ps
`include "crcu_defines.svh"
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ram_req, ram_ack, cpu_wait, irq, slow;
	logic [1:0] htrans;
	logic [1:0] idle_cnt = 2'h0;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [31:0] seed = 32'h00000034;
	logic [15:0] ram_addr, exp;
	logic [7:0] ram_rdata, q;
	logic [23:0] irq_vector;
	wire logic hready, ram_bus_idle;
	int errors = 0;
	int check_count = 0;
	int n, j, w;
	logic [1:0] xc = 2'h0;
	logic [14:0] ridx [10] = '{15'h7fb8, 15'h7fb9, 15'h7fba, 15'h7fbb, 15'h7fe6, 15'h7fe7,
		15'h7fec, 15'h7ffe, 15'h7fff, 15'h7f00};
	assign hready = hreadyout;
	// The bus is busy one cycle in four, so a fetch never waits for long.
	assign ram_bus_idle = idle_cnt != 2'h0;
	crcu_top i_crcu_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ram_req(ram_req),
		.ram_addr(ram_addr), .ram_ack(ram_ack), .ram_rdata(ram_rdata),
		.ram_bus_idle(ram_bus_idle), .cpu_wait(cpu_wait), .irq(irq), .irq_vector(irq_vector));
	crcu_ram_model i_crcu_ram_model (.hclk(hclk), .hresetn(hresetn), .ram_req(ram_req),
		.ram_addr(ram_addr), .slow(slow), .ram_ack(ram_ack), .ram_rdata(ram_rdata));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) idle_cnt <= idle_cnt + 2'h1;
	// Mid-cycle watch of the fetch port against the inhibit bits last written.
	always @(negedge hclk) begin
		if (hresetn === 1'b1) begin
			chk("cpu wait", {7'h00, ram_req && !xc[1]}, {7'h00, cpu_wait});
			if (ram_req === 1'b1) chk("steal gate", 8'h01, {7'h00, !xc[0] || ram_bus_idle});
		end
	end
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] crc_step(input logic [15:0] c, input int w,
		input logic [7:0] d, input logic msb);
		logic b;
		for (int k = 0; k < 8; k++) begin
			b = d[msb ? 7 - k : k] ^ c[w];
			c = ((c << 1) ^ (b ? 16'h1021 : 16'h0000)) & (16'hffff >> (15 - w));
		end
		return c;
	endfunction
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [14:0] idx, input logic [7:0] d,
		output logic [7:0] rd);
		hsel <= 1'b1;
		haddr <= {15'h0000, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'b00;
		hwdata <= {24'h000000, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata[7:0];
	endtask
	task automatic run_job(input logic [7:0] c);
		logic [7:0] s;
		bus(1'b1, `CRCU_IDX_CTRL, c, s);
		bus(1'b0, `CRCU_IDX_CTRL, 8'h00, s);
		chk("run set", 8'h01, {7'h00, s[5]});
		for (int k = 0; k < 200 && s[5] !== 1'b0; k++) bus(1'b0, `CRCU_IDX_CTRL, 8'h00, s);
		chk("run clear", 8'h00, {7'h00, s[5]});
		chk("done flag", 8'h01, {7'h00, s[1]});
		chk("irq", {7'h00, c[0]}, {7'h00, irq});
		bus(1'b1, `CRCU_IDX_CTRL, c & 8'h1d, s);
		bus(1'b0, `CRCU_IDX_CTRL, 8'h00, s);
		chk("control", c & 8'h1d, s);
		chk("irq cleared", 8'h00, {7'h00, irq});
		bus(1'b0, `CRCU_IDX_PAIR_LO, 8'h00, s);
		chk("crc low", exp[7:0], s);
		bus(1'b0, `CRCU_IDX_PAIR_HI, 8'h00, s);
		chk("crc high", exp[15:8], s);
	endtask
	task print_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge hclk);
		errors++;
		print_verdict();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		slow = 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (ridx[k]) begin
			bus(1'b0, ridx[k], 8'h00, q);
			chk("reset value", 8'h00, q);
		end
		bus(1'b1, `CRCU_IDX_XTEST, 8'h00, q);
		for (n = 0; n < 4; n++) begin
			w = n[1] ? 7 : 15;
			r = xs();
			bus(1'b1, `CRCU_IDX_WIDTH, w[7:0], q);
			bus(1'b1, `CRCU_IDX_CTRL, 8'h04, q);
			bus(1'b1, `CRCU_IDX_PAIR_LO, 8'h21, q);
			bus(1'b1, `CRCU_IDX_PAIR_HI, 8'h10, q);
			bus(1'b0, `CRCU_IDX_PAIR_HI, 8'h00, q);
			chk("poly high", 8'h10, q);
			bus(1'b1, `CRCU_IDX_CTRL, 8'h00, q);
			bus(1'b1, `CRCU_IDX_PAIR_LO, r[7:0], q);
			bus(1'b1, `CRCU_IDX_PAIR_HI, r[15:8], q);
			bus(1'b1, `CRCU_IDX_INBUF, r[23:16], q);
			bus(1'b0, `CRCU_IDX_INBUF, 8'h00, q);
			chk("input byte", r[23:16], q);
			exp = crc_step(r[15:0], w, r[23:16], n[0]);
			run_job({4'h2, n[0], 2'b00, n[1]});
		end
		for (n = 0; n < 2; n++) begin
			r = xs();
			slow <= n[0];
			xc = {n[0], !n[0]};
			bus(1'b1, `CRCU_IDX_XCTRL, {6'h00, xc}, q);
			bus(1'b1, `CRCU_IDX_WIDTH, 8'h0f, q);
			bus(1'b1, `CRCU_IDX_X3_ADDR_LO, 8'h30, q);
			bus(1'b1, `CRCU_IDX_X3_ADDR_HI, 8'h12, q);
			bus(1'b1, `CRCU_IDX_X3_COUNT, {6'h00, r[17:16]}, q);
			bus(1'b1, `CRCU_IDX_PAIR_LO, r[7:0], q);
			bus(1'b1, `CRCU_IDX_PAIR_HI, r[15:8], q);
			exp = r[15:0];
			for (j = 0; j < r[17:16] + 2; j++) exp = crc_step(exp, 15, (8'h30 + j[7:0]) ^ 8'ha5, r[20]);
			run_job({4'h3, r[20], 2'b00, 1'b1});
		end
		print_verdict();
	end
endmodule // tb
bind crcu_top crcu_checker i_crcu_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.ram_req(ram_req), .ram_addr(ram_addr), .ram_ack(ram_ack), .cpu_wait(cpu_wait),
	.irq(irq), .irq_vector(irq_vector));
